// File: dma_mode_and_status_flags_test.sv
`timescale 1ns/100ps
`default_nettype none
module dma_mode_and_status_flags_test;
	typedef struct packed {logic wr; logic [11:0] idx; logic [15:0] wd; logic [15:0] exp; logic err;} dmsf_row_t;
	localparam logic [11:0] CT = dmsf_pkg::IDX_SYS_DMA_CTRL;
	localparam logic [11:0] SF = dmsf_pkg::IDX_STATUS_FLAGS;
	localparam logic [11:0] SC = dmsf_pkg::IDX_STATUS_CLEAR;
	localparam logic [11:0] DM = dmsf_pkg::IDX_DISP_MODE;
	localparam logic [11:0] VC = dmsf_pkg::IDX_VERT_CYCLE;
	localparam logic [11:0] XC = dmsf_pkg::IDX_XFER_COUNT;
	localparam logic [11:0] IC = dmsf_pkg::IDX_IRQ_CLEAR;
	localparam logic [11:0] IE = dmsf_pkg::IDX_IRQ_ENABLE;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwd = 32'h00000000;
	logic pready, pslverr, rd_n, ack_n, xvalid, xactive, irq, busy, gerr;
	logic [31:0] prd, got;
	logic [15:0] xdata, xword;
	logic vsync = 1'b0;
	logic dend = 1'b0;
	logic even = 1'b0;
	logic dbuf = 1'b0;
	logic go = 1'b0;
	logic rd_first = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] last_word = 16'h0000;
	int err_total = 0;
	int checked = 0;
	int nvalid = 0;
	int cyc = 0;
	dmsf_row_t rows [10] = '{
		'{1'b0, SF, 16'h0000, 16'h0140, 1'b0},
		'{1'b0, VC, 16'h0000, 16'hFFFF, 1'b0},
		'{1'b1, CT, 16'h0004, 16'h0000, 1'b0},
		'{1'b0, CT, 16'h0000, 16'h0004, 1'b0},
		'{1'b1, CT, 16'h000C, 16'h0000, 1'b0},
		'{1'b0, CT, 16'h0000, 16'h0004, 1'b0},
		'{1'b1, CT, 16'h0008, 16'h0000, 1'b0},
		'{1'b1, SF, 16'hFFFF, 16'h0000, 1'b0},
		'{1'b0, SF, 16'h0000, 16'h0140, 1'b0},
		'{1'b0, 12'h001, 16'h0000, 16'h0000, 1'b1}};
	dmsf_regs DUT (.MCLK_IN(mclk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwd), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PRDATA_OUT(prd),
		.RD_N_IN(rd_n), .XFER_ACK_N_IN(ack_n), .XFER_DATA_IN(xdata), .EXT_VSYNC_IN(vsync), .DISP_END_IN(dend),
		.FIELD_EVEN_IN(even), .DISP_BUF_IN(dbuf), .XFER_WORD_OUT(xword), .XFER_VALID_OUT(xvalid),
		.XFER_ACTIVE_OUT(xactive), .IRQ_OUT(irq));
	dmsf_xfer_host host (.clk_in(mclk), .go_in(go), .rd_first_in(rd_first), .word_in(word), .rd_n_out(rd_n),
		.ack_n_out(ack_n), .data_out(xdata), .busy_out(busy));
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	task automatic give_verdict();
		$display("Mismatches %0d of %0d comparisons", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic cmpb(input logic g, input logic e, input string m);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] idx, input logic [15:0] d, output logic [31:0] r,
		output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= {idx, 2'b00};
		pwd <= {16'h0000, d};
		@(posedge mclk);
		pen <= 1'b1;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r = prd;
		er = pslverr;
		if (n >= 50)
			cmpb(1'b0, 1'b1, "bus answer");
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, got, gerr);
	endtask
	task automatic rc(input logic [11:0] idx, input logic [15:0] e, input string m);
		apb(1'b0, idx, 16'h0000, got, gerr);
		cmp(got, {16'h0000, e}, m);
	endtask
	task automatic send(input logic f, input logic [15:0] w);
		int n;
		n = 0;
		go <= 1'b1;
		rd_first <= f;
		word <= w;
		@(posedge mclk);
		go <= 1'b0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (busy !== 1'b0 && n < 40);
		if (n >= 40)
			cmpb(1'b0, 1'b1, "host answer");
	endtask
	task automatic dispend(input logic e);
		even <= e;
		dend <= 1'b1;
		@(posedge mclk);
		dend <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (xvalid === 1'b1)
		begin
			nvalid++;
			last_word = xword;
		end
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].idx, rows[i].wd, got, gerr);
			cmp(got, rows[i].wr ? 32'h00000000 : {16'h0000, rows[i].exp}, "row data");
			cmpb(gerr, rows[i].err, "row error");
		end
		wr(IE, 16'h0004);
		wr(XC, 16'h0001);
		wr(CT, 16'h0010);
		cmpb(xactive, 1'b1, "started");
		rc(SF, 16'h0140, "done cleared");
		send(1'b1, 16'h5AC3);
		cmp(last_word, 16'h5AC3, "first rise word");
		rc(SF, 16'h2140, "done set");
		cmpb(irq, 1'b1, "irq raised");
		wr(IE, 16'h0000);
		cmpb(irq, 1'b0, "irq masked");
		wr(IC, 16'h0004);
		wr(IE, 16'h0004);
		cmpb(irq, 1'b0, "irq cleared");
		wr(SC, 16'h2000);
		wr(CT, 16'h0014);
		send(1'b1, 16'h1E87);
		cmp(last_word, 16'hE178, "ack rise word");
		cmp(nvalid, 32'h00000002, "word count");
		wr(SC, 16'h2000);
		wr(XC, 16'h0005);
		wr(CT, 16'h0030);
		send(1'b0, 16'h33CC);
		wr(CT, 16'h0000);
		cmpb(xactive, 1'b0, "aborted");
		send(1'b0, 16'h7777);
		cmp(nvalid, 32'h00000003, "no transfer");
		rc(SF, 16'h0140, "no done");
		// Restart from the first word
		wr(XC, 16'h0001);
		wr(CT, 16'h0030);
		send(1'b0, 16'h0F0F);
		rc(SF, 16'h2140, "restart done");
		wr(SC, 16'h2000);
		wr(VC, 16'h0014);
		wr(DM, 16'h0002);
		repeat (10)
		begin
			vsync <= 1'b1;
			repeat (5) @(posedge mclk);
			vsync <= 1'b0;
			repeat (5) @(posedge mclk);
		end
		rc(SF, 16'h0140, "sync in time");
		repeat (40) @(posedge mclk);
		rc(SF, 16'h8140, "sync lost");
		wr(DM, 16'h0004);
		rc(SF, 16'h8140, "sync sticky");
		wr(SC, 16'h8000);
		rc(SF, 16'h0140, "sync cleared");
		dispend(1'b0);
		rc(SF, 16'h0140, "odd field");
		dispend(1'b1);
		rc(SF, 16'h4140, "even field");
		wr(CT, 16'h8000);
		rc(SF, 16'h0140, "display reset");
		// Mid-run reset keeps only the display buffer flag
		dbuf <= 1'b1;
		dispend(1'b1);
		wr(IE, 16'h0002);
		cmpb(irq, 1'b1, "frame irq");
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		cmpb(irq, 1'b0, "reset irq");
		cmpb(xactive, 1'b0, "reset active");
		rc(SF, 16'h0141, "reset image");
		rc(VC, 16'hFFFF, "reset cycle");
		give_verdict();
	end
endmodule
`default_nettype wire

// File: dmsf_pkg.sv
package dmsf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_SYS_DMA_CTRL = 12'h000;
	localparam logic [11:0] IDX_STATUS_FLAGS = 12'h002;
	localparam logic [11:0] IDX_STATUS_CLEAR = 12'h003;
	localparam logic [11:0] IDX_DISP_MODE = 12'h004;
	localparam logic [11:0] IDX_VERT_CYCLE = 12'h005;
	localparam logic [11:0] IDX_XFER_COUNT = 12'h006;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h007;
	localparam logic [11:0] IDX_IRQ_CLEAR = 12'h008;
	localparam logic [11:0] IDX_IRQ_ENABLE = 12'h009;

	// system_dma_control fields
	localparam int CTL_DISP_RESET = 15;
	localparam int CTL_MODE_LSB = 4;
	localparam int CTL_ADDR_LSB = 2;

	// Transfer mode codes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_DMA_A = 2'h1;
	localparam logic [1:0] MODE_DMA_B = 2'h3;

	// Address mode codes
	localparam logic [1:0] ADDR_SINGLE_EITHER = 2'h0;
	localparam logic [1:0] ADDR_SINGLE_ACK = 2'h1;
	localparam logic [1:0] ADDR_DUAL = 2'h2;
	localparam logic [1:0] ADDR_PROHIBITED = 2'h3;

	// status_flags and status_clear_reg bit positions
	localparam int ST_SYNC_ERR = 15;
	localparam int ST_FRAME = 14;
	localparam int ST_DONE = 13;
	localparam int ST_FIFO_EMPTY = 8;
	localparam int ST_OCC_LSB = 4;
	localparam int ST_DISP_BUF = 0;

	// display_mode_reg fields
	localparam int DM_TV_LSB = 0;
	localparam int DM_INTERLACE = 2;
	localparam logic [1:0] TV_SYNC_MODE = 2'h2;

	// Reset image
	localparam logic [3:0] RST_OCC = 4'h4;
	localparam logic RST_FIFO_EMPTY = 1'h1;
	localparam logic [15:0] RST_VERT_CYCLE = 16'hFFFF;

	// Interrupt bits
	localparam int IRQ_SYNC_ERR = 0;
	localparam int IRQ_FRAME = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_BITS = 3;
endpackage

// File: dmsf_regs.sv
// Overview of operation
// RL1 - Normal mode code performs no DMA transfer
// RL2 - Writing normal code aborts active transfer immediately
// RL3 - Host restarts aborted transfer from first word
// RL4 - Host avoids graphics memory access during DMA
// RL5 - Host polls done flag for start/end
// RL6 - Mode 00 latches on first strobe rise
// RL7 - Mode 01 latches on acknowledge rise only
// RL8 - Code 10 dual address; 11 never used
// RL9 - Host writes zero to reserved low bits
// RL10 - Internal state readable in status register
// RL11 - Reset image: occupancy 0100, empty 1
// RL12 - TV sync mode flags missing vsync rise
// RL13 - Sync error stays clear while vsync timely
// RL14 - Sync error sticky until reset or clear
// RL15 - Frame flag waits for display/even field end
// RL16 - Frame flag sets once per frame
// RL17 - Done flag sets when count reaches zero
// RL18 - Codes 01/11 start transfer, clear done
// RL19 - Status reads never change any flag
`timescale 1ns/100ps
`default_nettype none
module dmsf_regs #(
	parameter int CNT_W = 16
) (
	input wire logic MCLK_IN, // 10 MHz clock
	input wire logic NRST_IN, // Async reset, low
	input wire logic PSEL_IN, // APB select
	input wire logic PENABLE_IN, // APB enable
	input wire logic PWRITE_IN, // APB direction
	input wire logic [13:0] PADDR_IN, // APB byte address
	input wire logic [31:0] PWDATA_IN, // APB write data
	output logic PREADY_OUT, // APB ready
	output logic PSLVERR_OUT, // APB error, unmapped
	output logic [31:0] PRDATA_OUT, // APB read data
	input wire logic RD_N_IN, // Read strobe pin, low
	input wire logic XFER_ACK_N_IN, // DMA acknowledge pin, low
	input wire logic [15:0] XFER_DATA_IN, // DMA data pins
	input wire logic EXT_VSYNC_IN, // External vertical sync pin
	input wire logic DISP_END_IN, // End of display pulse
	input wire logic FIELD_EVEN_IN, // Current field is even
	input wire logic DISP_BUF_IN, // Display buffer flag
	output logic [15:0] XFER_WORD_OUT, // Latched DMA word
	output logic XFER_VALID_OUT, // Word valid pulse
	output logic XFER_ACTIVE_OUT, // DMA transfer running
	output logic IRQ_OUT // Interrupt level
);
	typedef struct packed {
		logic [1:0] xfer_mode;
		logic [1:0] addr_mode;
		logic xfer_active;
		logic xfer_done;
		logic [CNT_W-1:0] count_cfg;
		logic [CNT_W-1:0] remain;
		logic sync_err;
		logic frame;
		logic [3:0] occ;
		logic fifo_empty;
		logic [1:0] tv_mode;
		logic interlace;
		logic [15:0] vcycle;
		logic [15:0] vcount;
		logic rd_s1;
		logic rd_s2;
		logic ack_s1;
		logic ack_s2;
		logic vs_s1;
		logic vs_s2;
		logic [15:0] data_s1;
		logic [15:0] data_s2;
		logic comb_d;
		logic ack_d;
		logic vs_d;
		logic [15:0] xfer_word;
		logic xfer_valid;
		logic [dmsf_pkg::IRQ_BITS-1:0] irq_stat;
		logic [dmsf_pkg::IRQ_BITS-1:0] irq_en;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dmsf_state_t;

	dmsf_state_t r;
	dmsf_state_t next_r;
	logic acc_wr;
	logic acc_rd;
	logic [11:0] idx;
	logic mapped;
	logic comb_rise;
	logic ack_rise;
	logic vs_rise;
	logic latch;
	logic [1:0] wr_mode;
	logic wr_display_reset_bit;
	logic clr_done;
	logic [dmsf_pkg::IRQ_BITS-1:0] ev;

	always_comb
	begin
		idx = PADDR_IN[13:2];
		mapped = (idx == dmsf_pkg::IDX_SYS_DMA_CTRL) || (idx == dmsf_pkg::IDX_STATUS_FLAGS)
			|| (idx == dmsf_pkg::IDX_STATUS_CLEAR) || (idx == dmsf_pkg::IDX_DISP_MODE)
			|| (idx == dmsf_pkg::IDX_VERT_CYCLE) || (idx == dmsf_pkg::IDX_XFER_COUNT)
			|| (idx == dmsf_pkg::IDX_IRQ_STATUS) || (idx == dmsf_pkg::IDX_IRQ_CLEAR)
			|| (idx == dmsf_pkg::IDX_IRQ_ENABLE);
		acc_wr = PSEL_IN && PENABLE_IN && r.pready && PWRITE_IN && mapped;
		acc_rd = PSEL_IN && PENABLE_IN && !r.pready && !PWRITE_IN;
		wr_mode = PWDATA_IN[dmsf_pkg::CTL_MODE_LSB +: 2];
		wr_display_reset_bit = acc_wr && (idx == dmsf_pkg::IDX_SYS_DMA_CTRL) && PWDATA_IN[dmsf_pkg::CTL_DISP_RESET];
		clr_done = acc_wr && (idx == dmsf_pkg::IDX_STATUS_CLEAR) && PWDATA_IN[dmsf_pkg::ST_DONE];
		// First of the two strobes to rise ends the combined low pulse
		comb_rise = (r.rd_s2 | r.ack_s2) && !r.comb_d;
		ack_rise = r.ack_s2 && !r.ack_d;
		vs_rise = r.vs_s2 && !r.vs_d;
		latch = r.xfer_active && ((r.addr_mode == dmsf_pkg::ADDR_SINGLE_EITHER) ? comb_rise : ack_rise); // see RL6 RL7
	end

	always_comb
	begin
		next_r = r;
		ev = '0;
		next_r.rd_s1 = RD_N_IN;
		next_r.rd_s2 = r.rd_s1;
		next_r.ack_s1 = XFER_ACK_N_IN;
		next_r.ack_s2 = r.ack_s1;
		next_r.vs_s1 = EXT_VSYNC_IN;
		next_r.vs_s2 = r.vs_s1;
		next_r.data_s1 = XFER_DATA_IN;
		next_r.data_s2 = r.data_s1;
		next_r.comb_d = r.rd_s2 | r.ack_s2;
		next_r.ack_d = r.ack_s2;
		next_r.vs_d = r.vs_s2;
		next_r.xfer_valid = 1'b0;
		next_r.fifo_empty = 1'b1;

		// DMA word capture and countdown
		if (latch)
		begin
			next_r.xfer_word = r.data_s2;
			next_r.xfer_valid = 1'b1;
			next_r.fifo_empty = 1'b0;
			next_r.remain = r.remain - 1'b1;
		end
		if (r.xfer_active && r.remain == '0)
		begin
			next_r.xfer_active = 1'b0;
			ev[dmsf_pkg::IRQ_DONE] = 1'b1;
		end

		// Vertical sync watchdog
		if (r.tv_mode != dmsf_pkg::TV_SYNC_MODE || vs_rise)
			next_r.vcount = '0;
		else if (r.vcount >= r.vcycle)
		begin
			next_r.vcount = '0;
			ev[dmsf_pkg::IRQ_SYNC_ERR] = 1'b1; // see RL12
		end
		else
			next_r.vcount = r.vcount + 16'h0001;

		// Frame end: every display, or even field only when interlaced
		if (DISP_END_IN && (!r.interlace || FIELD_EVEN_IN))
			ev[dmsf_pkg::IRQ_FRAME] = 1'b1; // see RL15 RL16

		// APB answer one cycle into the access phase
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		if (PSEL_IN && PENABLE_IN && !r.pready)
		begin
			next_r.pready = 1'b1;
			next_r.pslverr = !mapped;
			next_r.prdata = '0;
			if (!PWRITE_IN)
			begin
				case (idx)
					dmsf_pkg::IDX_SYS_DMA_CTRL:
						next_r.prdata[5:2] = {r.xfer_mode, r.addr_mode};
					dmsf_pkg::IDX_STATUS_FLAGS:
					begin
						// Read only samples flags; nothing is cleared here
						next_r.prdata[dmsf_pkg::ST_SYNC_ERR] = r.sync_err; // see RL10 RL19
						next_r.prdata[dmsf_pkg::ST_FRAME] = r.frame;
						next_r.prdata[dmsf_pkg::ST_DONE] = r.xfer_done;
						next_r.prdata[dmsf_pkg::ST_FIFO_EMPTY] = r.fifo_empty;
						next_r.prdata[dmsf_pkg::ST_OCC_LSB +: 4] = r.occ;
						next_r.prdata[dmsf_pkg::ST_DISP_BUF] = DISP_BUF_IN;
					end
					dmsf_pkg::IDX_DISP_MODE:
						next_r.prdata[2:0] = {r.interlace, r.tv_mode};
					dmsf_pkg::IDX_VERT_CYCLE:
						next_r.prdata[15:0] = r.vcycle;
					dmsf_pkg::IDX_XFER_COUNT:
						next_r.prdata[CNT_W-1:0] = r.count_cfg;
					dmsf_pkg::IDX_IRQ_STATUS:
						next_r.prdata[dmsf_pkg::IRQ_BITS-1:0] = r.irq_stat;
					dmsf_pkg::IDX_IRQ_ENABLE:
						next_r.prdata[dmsf_pkg::IRQ_BITS-1:0] = r.irq_en;
					default:
						next_r.prdata = '0;
				endcase
			end
		end

		// Register writes; clears come first so a same-cycle set wins, except a start write, which cancels a same-cycle done event
		if (acc_wr)
		begin
			case (idx)
				dmsf_pkg::IDX_SYS_DMA_CTRL:
				begin
					next_r.xfer_mode = wr_mode;
					if (wr_mode == dmsf_pkg::MODE_DMA_A || wr_mode == dmsf_pkg::MODE_DMA_B)
					begin
						next_r.xfer_active = 1'b1; // see RL18
						next_r.xfer_done = 1'b0;
						next_r.remain = r.count_cfg;
						ev[dmsf_pkg::IRQ_DONE] = 1'b0;
					end
					else
						next_r.xfer_active = 1'b0; // see RL1 RL2
					if (PWDATA_IN[dmsf_pkg::CTL_ADDR_LSB +: 2] != dmsf_pkg::ADDR_PROHIBITED)
						next_r.addr_mode = PWDATA_IN[dmsf_pkg::CTL_ADDR_LSB +: 2]; // see RL8
					if (wr_display_reset_bit)
					begin
						next_r.sync_err = 1'b0; // see RL13
						next_r.frame = 1'b0;
						next_r.vcount = '0;
					end
				end
				dmsf_pkg::IDX_STATUS_CLEAR:
				begin
					if (PWDATA_IN[dmsf_pkg::ST_SYNC_ERR])
						next_r.sync_err = 1'b0;
					if (PWDATA_IN[dmsf_pkg::ST_FRAME])
						next_r.frame = 1'b0;
					if (PWDATA_IN[dmsf_pkg::ST_DONE])
						next_r.xfer_done = 1'b0;
				end
				dmsf_pkg::IDX_DISP_MODE:
				begin
					next_r.tv_mode = PWDATA_IN[dmsf_pkg::DM_TV_LSB +: 2];
					next_r.interlace = PWDATA_IN[dmsf_pkg::DM_INTERLACE];
				end
				dmsf_pkg::IDX_VERT_CYCLE:
					next_r.vcycle = PWDATA_IN[15:0];
				dmsf_pkg::IDX_XFER_COUNT:
					next_r.count_cfg = PWDATA_IN[CNT_W-1:0];
				dmsf_pkg::IDX_IRQ_CLEAR:
					next_r.irq_stat = r.irq_stat & ~PWDATA_IN[dmsf_pkg::IRQ_BITS-1:0];
				dmsf_pkg::IDX_IRQ_ENABLE:
					next_r.irq_en = PWDATA_IN[dmsf_pkg::IRQ_BITS-1:0];
				default:
					next_r.irq_en = r.irq_en;
			endcase
		end

		// Hardware sets, sticky until reset or software clear
		if (ev[dmsf_pkg::IRQ_SYNC_ERR])
			next_r.sync_err = 1'b1; // see RL14
		if (ev[dmsf_pkg::IRQ_FRAME])
			next_r.frame = 1'b1;
		if (ev[dmsf_pkg::IRQ_DONE])
			next_r.xfer_done = 1'b1; // see RL17
		next_r.irq_stat = next_r.irq_stat | ev;
		next_r.irq = |(next_r.irq_stat & next_r.irq_en);
	end

	always_ff @(posedge MCLK_IN or negedge NRST_IN)
	begin
		if (!NRST_IN)
		begin
			r <= '0;
			r.occ <= dmsf_pkg::RST_OCC; // see RL11
			r.fifo_empty <= dmsf_pkg::RST_FIFO_EMPTY;
			r.vcycle <= dmsf_pkg::RST_VERT_CYCLE;
			r.rd_s1 <= 1'b1;
			r.rd_s2 <= 1'b1;
			r.ack_s1 <= 1'b1;
			r.ack_s2 <= 1'b1;
			r.comb_d <= 1'b1;
			r.ack_d <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign PREADY_OUT = r.pready;
	assign PSLVERR_OUT = r.pslverr;
	assign PRDATA_OUT = r.prdata;
	assign XFER_WORD_OUT = r.xfer_word;
	assign XFER_VALID_OUT = r.xfer_valid;
	assign XFER_ACTIVE_OUT = r.xfer_active;
	assign IRQ_OUT = r.irq;

	chk_abort_stops_xfer: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL2
		acc_wr && idx == dmsf_pkg::IDX_SYS_DMA_CTRL && wr_mode == dmsf_pkg::MODE_NORMAL |=> !r.xfer_active)
		else $error("transfer still active after abort write");
	chk_normal_no_words: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL1
		r.xfer_mode == dmsf_pkg::MODE_NORMAL |=> !r.xfer_valid)
		else $error("word latched in normal mode");
	chk_start_clears_done: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL18
		acc_wr && idx == dmsf_pkg::IDX_SYS_DMA_CTRL && wr_mode == dmsf_pkg::MODE_DMA_A
		|=> !r.xfer_done && r.xfer_active && r.remain == $past(r.count_cfg))
		else $error("start did not load count or clear done");
	chk_addr_not_prohib: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL8
		r.addr_mode != dmsf_pkg::ADDR_PROHIBITED)
		else $error("prohibited address mode stored");
	chk_either_latch: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL6
		r.xfer_active && r.addr_mode == dmsf_pkg::ADDR_SINGLE_EITHER && comb_rise
		|=> r.xfer_valid && r.xfer_word == $past(r.data_s2))
		else $error("first strobe rise missed");
	chk_ack_only: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL7
		r.addr_mode == dmsf_pkg::ADDR_SINGLE_ACK && !ack_rise |=> !r.xfer_valid)
		else $error("read strobe latched in acknowledge mode");
	chk_done_at_zero: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL17
		r.xfer_active && r.remain == '0 |=> r.xfer_done ##1 (r.xfer_done || $past(clr_done)))
		else $error("done flag not set at zero count");
	chk_sync_timeout: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL12
		r.tv_mode == dmsf_pkg::TV_SYNC_MODE && !vs_rise && r.vcount >= r.vcycle |=> r.sync_err)
		else $error("missing vsync not flagged");
	chk_sync_sticky: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL14
		r.sync_err && !(acc_wr && (wr_display_reset_bit || (idx == dmsf_pkg::IDX_STATUS_CLEAR
		&& PWDATA_IN[dmsf_pkg::ST_SYNC_ERR]))) |=> r.sync_err)
		else $error("sync error dropped without clear");
	chk_odd_field_hold: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL15
		r.interlace && !r.frame && !(DISP_END_IN && FIELD_EVEN_IN) |=> !r.frame)
		else $error("frame flag set outside even field end");
	chk_read_keeps: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN) // see RL19
		acc_rd && ev == '0 && !acc_wr |=> $stable({r.sync_err, r.frame, r.xfer_done}))
		else $error("status read changed a flag");
endmodule
`default_nettype wire

// File: dmsf_xfer_host.sv
`timescale 1ns/100ps
`default_nettype none
module dmsf_xfer_host (
	input wire logic clk_in, // Device clock
	input wire logic go_in, // Send one word
	input wire logic rd_first_in, // Read strobe rises first
	input wire logic [15:0] word_in, // Word to send
	output logic rd_n_out, // Read strobe
	output logic ack_n_out, // DMA acknowledge
	output logic [15:0] data_out, // Data pins
	output logic busy_out // Word in flight
);
	int step = 0;
	initial
	begin
		rd_n_out = 1'b1;
		ack_n_out = 1'b1;
		data_out = 16'h0000;
		busy_out = 1'b0;
	end
	// Only DMA pins are driven, never graphics memory
	always @(posedge clk_in)
	begin
		step <= (step == 0) ? (go_in ? 1 : 0) : (step == 16 ? 0 : step + 1);
		if (step == 0 || step > 12)
		begin
			data_out <= ~data_out;
		end
		if (step == 0 && go_in)
		begin
			busy_out <= 1'b1;
			data_out <= word_in;
			rd_n_out <= 1'b0;
			ack_n_out <= 1'b0;
		end
		if (step == 5)
		begin
			rd_n_out <= rd_first_in;
		end
		// Data moves on once the read strobe has risen
		if (step == 7 && rd_first_in)
		begin
			data_out <= ~word_in;
		end
		if (step == 10)
		begin
			rd_n_out <= 1'b1;
			ack_n_out <= 1'b1;
		end
		if (step == 16)
		begin
			busy_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire
